// *** logic/uart_bg_pkg.sv ***
/*
 * Shared constants for the baud rate generator with internal loopback:
 * register offsets, field positions, reset values and setting limits.
 * Assumes an 8-bit register port with a 3-bit byte address.
 */
package uart_bg_pkg;
   // --------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------
   localparam logic [2:0] OFF_DIV_LOW = 3'h0;
   localparam logic [2:0] OFF_DIV_HIGH = 3'h1;
   localparam logic [2:0] OFF_SAMPLE_CLOCK = 3'h2;
   localparam logic [2:0] OFF_PRESCALE_EXP = 3'h3;
   localparam logic [2:0] OFF_PRESCALE_OFF = 3'h4;
   localparam logic [2:0] OFF_MODEM_CTRL = 3'h5;
   localparam logic [2:0] OFF_MODE = 3'h6;
   localparam logic [2:0] OFF_STATUS = 3'h7;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int MODEM_LOOPBACK_BIT = 4;
   localparam int MODE_ENHANCED_BIT = 0;
   localparam int STAT_LOOPBACK_BIT = 0;
   localparam int STAT_ENHANCED_BIT = 1;
   localparam int STAT_RUNNING_BIT = 2;

   // --------------------------------------------------------------
   // Reset values and legal ranges
   // --------------------------------------------------------------
   localparam logic [7:0] RST_DIV_LOW = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [3:0] RST_SAMPLE_CLOCK = 4'h0;
   localparam logic [1:0] RST_PRESCALE_EXP = 2'h1;
   localparam logic [2:0] RST_PRESCALE_OFF = 3'h0;
   localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
   localparam logic RST_ENHANCED = 1'b0;
   localparam logic [3:0] SAMPLE_CLOCK_MAX = 4'hC;
   localparam logic [1:0] PRESCALE_EXP_MIN = 2'h1;
   localparam logic [1:0] PRESCALE_EXP_MAX = 2'h2;
   localparam logic [4:0] SAMPLE_BASE = 5'h10;
   localparam logic [6:0] LEGACY_PRESCALE = 7'h10;
endpackage : uart_bg_pkg

// *** logic/rate_counter.sv ***
/*
 * Reloading fractional rate counter. Each clock adds step to an
 * accumulator; when the sum reaches period it reloads with the remainder
 * and emits a one-cycle tick, so ticks average step/period per clock.
 * Assumes step does not exceed period; otherwise the rate saturates.
 */
`timescale 1ns/10ps
`default_nettype none
module rate_counter #(
   parameter int ACC_W = 23,
   parameter int STEP_W = 5
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Settings
   input wire logic enable,
   input wire logic [ACC_W-1:0] period,
   input wire logic [STEP_W-1:0] step,
   // Output
   output logic tick_q
);
   initial begin
      if (STEP_W > ACC_W) $error("rate_counter: STEP_W wider than ACC_W");
   end

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W:0] sum;
   logic [ACC_W:0] rem;
   logic reach;

   // -----------------------------------------------------------
   // Accumulate and reload
   // -----------------------------------------------------------
   assign sum = {1'b0, acc_q} + {{(ACC_W + 1 - STEP_W){1'b0}}, step};
   assign reach = sum >= {1'b0, period};
   assign rem = sum - {1'b0, period};

   // A zero period stops the counter rather than ticking every clock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end else if (!enable || period == '0) begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end else if (reach) begin
         // A period shrunk by software leaves a stale remainder; drop it so the rate recovers at once
         acc_q <= (rem >= {1'b0, period}) ? '0 : rem[ACC_W-1:0]; // see RULE11
         tick_q <= 1'b1;
      end else begin
         acc_q <= sum[ACC_W-1:0];
         tick_q <= 1'b0;
      end
   end
endmodule : rate_counter
`default_nettype wire

// *** logic/uart_baud_gen_loopback.sv ***
/*
 * Per-channel bit rate generator with diagnostic internal loopback.
 * Holds the divisor, sample clock, prescale and modem control registers,
 * derives sample and bit strobes from mclk, and steers the serial path.
 * Assumes the transmit and receive shift registers run on mclk and
 * the serial input pin is asynchronous to it.
 */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: modem_control_reg bit 4 set selects internal loopback; clear is normal.
// RULE2: In loopback the transmit shift output feeds the receive shift input.
// RULE3: Bit rate equals input clock over divisor times prescaler.
// RULE4: Divisor is low byte plus 256 times high byte.
// RULE5: Prescaler is two to the exponent times (sample count plus offset).
// RULE6: Sample count is sixteen minus sample_clock_reg; software writes 0h to Ch.
// RULE7: Exponent comes from prescale_exponent; software writes 01h to 02h.
// RULE8: Offset comes from prescale_offset; software writes 0h to 7h.
// RULE9: Software avoids zero sample count, divisor or prescaler.
// RULE10: Flexible prescaler and sample clock act only in enhanced mode.
// RULE11: Reloading counter gives sample strobes; sample-count strobes make one bit.
module uart_baud_gen_loopback
   import uart_bg_pkg::*;
#(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Serial path
   input wire logic tx_shift_out,
   output logic rx_shift_in,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   // Strobes
   output logic sample_tick,
   output logic bit_tick
);
   initial begin
      if (DIV_W != 16) $error("uart_baud_gen_loopback: divisor must be 16 bits");
   end

   localparam int PRE_W = 7;
   localparam int ACC_W = DIV_W + PRE_W;
   // Prescaler fits seven bits: the largest legal value is (16 + 7) << 2

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   // Sample clocks per bit; fixed at sixteen outside enhanced mode
   function automatic logic [4:0] sample_count(input logic [3:0] sclk_val, input logic enh);
      sample_count = enh ? SAMPLE_BASE - {1'b0, sclk_val} : SAMPLE_BASE; // see RULE6 see RULE10
   endfunction : sample_count

   // Write strobe decode for one register offset
   function automatic logic wr_hit(input logic [2:0] addr, input logic [2:0] off, input logic wr);
      wr_hit = wr && (addr == off);
   endfunction : wr_hit

   // -----------------------------------------------------------
   // Registers
   // -----------------------------------------------------------
   logic [7:0] div_low_q;
   logic [7:0] divisor_high_byte_q;
   logic [3:0] sample_clock_reg_q;
   logic [1:0] prescale_exponent_q;
   logic [2:0] prescale_offset_q;
   logic [7:0] modem_control_reg_q;
   logic enhanced_q;
   logic [7:0] reg_rdata_q;

   logic scr_ok;
   logic exp_ok;
   assign scr_ok = reg_wdata[7:4] == 4'h0 && reg_wdata[3:0] <= SAMPLE_CLOCK_MAX;
   assign exp_ok = reg_wdata >= {6'h00, PRESCALE_EXP_MIN} && reg_wdata <= {6'h00, PRESCALE_EXP_MAX};

   // Out-of-range writes to limited fields are dropped so the count never hits zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_low_q <= RST_DIV_LOW;
         divisor_high_byte_q <= RST_DIV_HIGH;
         sample_clock_reg_q <= RST_SAMPLE_CLOCK;
         prescale_exponent_q <= RST_PRESCALE_EXP;
         prescale_offset_q <= RST_PRESCALE_OFF;
         modem_control_reg_q <= RST_MODEM_CTRL;
         enhanced_q <= RST_ENHANCED;
      end else begin
         if (wr_hit(reg_addr, OFF_DIV_LOW, reg_write)) div_low_q <= reg_wdata;
         if (wr_hit(reg_addr, OFF_DIV_HIGH, reg_write)) divisor_high_byte_q <= reg_wdata;
         if (wr_hit(reg_addr, OFF_SAMPLE_CLOCK, reg_write) && scr_ok)
            sample_clock_reg_q <= reg_wdata[3:0]; // see RULE6
         if (wr_hit(reg_addr, OFF_PRESCALE_EXP, reg_write) && exp_ok)
            prescale_exponent_q <= reg_wdata[1:0]; // see RULE7
         if (wr_hit(reg_addr, OFF_PRESCALE_OFF, reg_write) && reg_wdata[7:3] == 5'h00)
            prescale_offset_q <= reg_wdata[2:0]; // see RULE8
         if (wr_hit(reg_addr, OFF_MODEM_CTRL, reg_write)) modem_control_reg_q <= reg_wdata;
         if (wr_hit(reg_addr, OFF_MODE, reg_write)) enhanced_q <= reg_wdata[MODE_ENHANCED_BIT];
      end
   end

   // -----------------------------------------------------------
   // Rate arithmetic
   // -----------------------------------------------------------
   logic [DIV_W-1:0] divisor;
   logic [4:0] samples;
   logic [PRE_W-1:0] prescaler;
   logic [ACC_W-1:0] period;
   logic loopback;
   logic running;

   assign divisor = {divisor_high_byte_q, div_low_q}; // see RULE4
   assign samples = sample_count(sample_clock_reg_q, enhanced_q);
   // Legacy mode keeps the plain divide-by-sixteen prescaler
   assign prescaler = enhanced_q
      ? PRE_W'({2'b00, samples} + {4'h0, prescale_offset_q}) << prescale_exponent_q // see RULE5 see RULE10
      : LEGACY_PRESCALE;
   // Both factors widened to the full product width so no high bits are lost
   assign period = {{PRE_W{1'b0}}, divisor} * {{DIV_W{1'b0}}, prescaler}; // see RULE3
   // Zero settings stop the generator instead of running wild
   assign running = divisor != '0 && prescaler != '0 && samples != '0; // see RULE9
   // Loopback takes effect on the edge after the control write lands
   assign loopback = modem_control_reg_q[MODEM_LOOPBACK_BIT]; // see RULE1

   // -----------------------------------------------------------
   // Sample strobe: samples per period of divisor times prescaler
   // -----------------------------------------------------------
   // Step is the sample count, so S strobes fall in every period of P clocks
   rate_counter #(
      .ACC_W(ACC_W),
      .STEP_W(5)
   ) u_rate (
      .mclk(mclk),
      .rst(rst),
      .enable(running),
      .period(period),
      .step(samples),
      .tick_q(sample_tick) // see RULE11
   );

   // -----------------------------------------------------------
   // Bit strobe: one per sample-count sample strobes
   // -----------------------------------------------------------
   logic [4:0] sample_idx_q;
   logic bit_tick_q;
   logic last_sample;
   // A sample count shrunk to or below the current index ends the current bit at the next strobe
   assign last_sample = sample_idx_q >= samples - 5'h01;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sample_idx_q <= 5'h00;
         bit_tick_q <= 1'b0;
      end else begin
         bit_tick_q <= sample_tick && last_sample; // see RULE11
         if (!running) sample_idx_q <= 5'h00;
         else if (sample_tick) sample_idx_q <= last_sample ? 5'h00 : sample_idx_q + 5'h01;
      end
   end
   assign bit_tick = bit_tick_q;

   // -----------------------------------------------------------
   // Serial path with loopback
   // -----------------------------------------------------------
   logic pin_meta_q;
   logic pin_sync_q;
   logic rx_shift_in_q;
   logic serial_out_q;

   // Pin is asynchronous; two stages before anything reads it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_meta_q <= 1'b1;
         pin_sync_q <= 1'b1;
      end else begin
         pin_meta_q <= serial_in_pin;
         pin_sync_q <= pin_meta_q;
      end
   end

   // Line is parked at idle mark while looped so the far end sees nothing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_shift_in_q <= 1'b1;
         serial_out_q <= 1'b1;
      end else begin
         rx_shift_in_q <= loopback ? tx_shift_out : pin_sync_q; // see RULE2
         serial_out_q <= loopback ? 1'b1 : tx_shift_out; // see RULE1
      end
   end
   assign rx_shift_in = rx_shift_in_q;
   assign serial_out_pin = serial_out_q;

   // -----------------------------------------------------------
   // Read port: data in the cycle after the read strobe
   // -----------------------------------------------------------
   logic [7:0] rd_mux;
   logic [7:0] status;
   // Status is read-only; writes to its offset are ignored
   assign status = {5'h00, running, enhanced_q, loopback};
   assign rd_mux =
      (reg_addr == OFF_DIV_LOW) ? div_low_q :
      (reg_addr == OFF_DIV_HIGH) ? divisor_high_byte_q :
      (reg_addr == OFF_SAMPLE_CLOCK) ? {4'h0, sample_clock_reg_q} :
      (reg_addr == OFF_PRESCALE_EXP) ? {6'h00, prescale_exponent_q} :
      (reg_addr == OFF_PRESCALE_OFF) ? {5'h00, prescale_offset_q} :
      (reg_addr == OFF_MODEM_CTRL) ? modem_control_reg_q :
      (reg_addr == OFF_MODE) ? {7'h00, enhanced_q} :
      status;

   // Idle cycles return zero so a stale value never looks like fresh data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) reg_rdata_q <= 8'h00;
      else reg_rdata_q <= reg_read ? rd_mux : 8'h00;
   end
   assign reg_rdata = reg_rdata_q;
endmodule : uart_baud_gen_loopback
`default_nettype wire

// *** bench/uart_bg_properties.sv ***
/* Port checker for the rate generator with loopback.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module uart_bg_checker
   import uart_bg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Serial path and strobes
   input wire logic tx_shift_out,
   input wire logic rx_shift_in,
   input wire logic serial_in_pin,
   input wire logic serial_out_pin,
   input wire logic sample_tick,
   input wire logic bit_tick
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic lb_q;
   logic enh_q;
   logic [1:0] settle_q;
   // Mirror of loopback and mode bits; settle_q keeps $past away from reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lb_q <= 1'b0;
         enh_q <= 1'b0;
         settle_q <= 2'h0;
      end else begin
         if (reg_write && reg_addr == OFF_MODEM_CTRL) lb_q <= reg_wdata[4];
         if (reg_write && reg_addr == OFF_MODE) enh_q <= reg_wdata[0];
         if (settle_q != 2'h3) settle_q <= settle_q + 2'h1;
      end
   end
   rdata_idle_a: assert property (settle_q == 2'h3 && !$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   loop_path_a: assert property (lb_q && $past(lb_q) |-> rx_shift_in == $past(tx_shift_out))
      else $error("loopback path broken");
   loop_quiet_a: assert property (lb_q && $past(lb_q) |-> serial_out_pin)
      else $error("output pin not idle in loopback");
   tx_follow_a: assert property (settle_q == 2'h3 && !lb_q && !$past(lb_q)
      |-> serial_out_pin == $past(tx_shift_out)) else $error("output pin not following");
   pin_sync_a: assert property (settle_q == 2'h3 && !lb_q && !$past(lb_q)
      |-> rx_shift_in == $past(serial_in_pin, 3)) else $error("pin path broken");
   bit_sample_a: assert property (bit_tick |-> $past(sample_tick))
      else $error("bit strobe without sample strobe");
   bit_gap_a: assert property (bit_tick |=> !bit_tick [*3])
      else $error("bit strobes too close");
   modem_read_a: assert property (reg_read && reg_addr == OFF_MODEM_CTRL |=> reg_rdata[4] == lb_q)
      else $error("loopback bit readback");
   status_read_a: assert property (reg_read && reg_addr == OFF_STATUS
      |=> reg_rdata[1:0] == {enh_q, lb_q}) else $error("status mode bits");
endmodule : uart_bg_checker
`default_nettype wire

// *** bench/tx_source.sv ***
/* Transmit shift register stand-in: a new bit on each bit strobe.
   Assumes the generator's bit strobe on the same clock. */
`timescale 1ns/10ps
`default_nettype none
module tx_source (
   // Clock, reset and pacing
   input wire logic mclk,
   input wire logic rst,
   input wire logic bit_tick,
   // Serial output
   output logic tx_shift_out
);
   logic [7:0] lfsr_q;
   // Bits hold for a whole bit period, as a real shifter does
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lfsr_q <= 8'hA5;
         tx_shift_out <= 1'b1;
      end else if (bit_tick) begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         tx_shift_out <= lfsr_q[0];
      end
   end
endmodule : tx_source
`default_nettype wire

// *** bench/testbench.sv ***
/* Self-checking bench: reset values, rates, refused writes, serial paths.
   Assumes the generator, the checker and the transmit stand-in. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import uart_bg_pkg::*;
   logic mclk, rst, reg_write, reg_read, tx_shift_out, rx_shift_in, serial_in_pin;
   logic serial_out_pin, sample_tick, bit_tick, tx_prev;
   logic [2:0] reg_addr, ph;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [31:0] seed;
   int err_count, checks_done, ns, nb, d, sc, e, o;
   logic [7:0] rv [8] = '{RST_DIV_LOW, RST_DIV_HIGH, 8'(RST_SAMPLE_CLOCK), 8'(RST_PRESCALE_EXP),
      8'(RST_PRESCALE_OFF), RST_MODEM_CTRL, 8'(RST_ENHANCED), 8'h04};
   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   uart_baud_gen_loopback uart_baud_gen_loopback_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .sample_tick(sample_tick), .bit_tick(bit_tick));
   tx_source tx_source_i (.mclk(mclk), .rst(rst), .bit_tick(bit_tick), .tx_shift_out(tx_shift_out));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // Cycles per bit: divisor times prescaler, legacy prescaler fixed at 16
   function automatic int rate_p(int dv, int s, int ex, int of, bit enh);
      return enh ? dv * ((s + of) << ex) : dv * 16;
   endfunction : rate_p
   task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(logic [2:0] a, logic [7:0] dt);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= dt;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(logic [2:0] a, output logic [7:0] dt);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 dt = reg_rdata;
   endtask : rd
   // Over any P cycles the accumulator wraps exactly S times, one bit
   task automatic measure(int p, int s);
      ns = 0;
      nb = 0;
      repeat (2 * p) @(posedge mclk);
      repeat (p) begin
         @(posedge mclk);
         #1 ns += sample_tick;
         nb += bit_tick;
      end
      chk("sample ticks", 16'(ns), 16'(s));
      chk("bit ticks", 16'(nb), 16'h0001);
   endtask : measure
   // Random pin traffic; rx and the output pin checked against their sources
   task automatic path_run(bit lb);
      for (int k = 0; k < 40; k++) begin
         @(posedge mclk);
         serial_in_pin <= seed[0];
         seed = xs(seed);
         #1 if (k > 3) begin
            chk("rx path", 16'(rx_shift_in), 16'(lb ? tx_prev : ph[2]));
            chk("out pin", 16'(serial_out_pin), 16'(lb ? 1'b1 : tx_prev));
         end
         ph = {ph[1:0], serial_in_pin};
         tx_prev = tx_shift_out;
      end
      $display("path test done");
   endtask : path_run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Watchdog well beyond the longest expected run
   initial begin
      #(50 * 60000);
      err_count++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1; reg_addr = 3'h0; reg_wdata = 8'h00; reg_write = 1'b0; reg_read = 1'b0;
      serial_in_pin = 1'b1; seed = 32'hB0AD4065; err_count = 0; checks_done = 0; ph = 3'h7;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], v);
         chk("reset value", 16'(v), 16'(rv[a]));
      end
      $display("reset test done");
      // Pass 0 legacy with divisor 256, pass 1 the extreme legal enhanced setting
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         d = (i == 0) ? 256 : 1 + seed[1:0];
         sc = (i == 1) ? 12 : seed[7:4] % 13;
         e = (i == 1) ? 2 : 1 + seed[8];
         o = (i == 1) ? 7 : seed[11:9];
         wr(OFF_DIV_LOW, 8'(d)); wr(OFF_DIV_HIGH, 8'(d >> 8)); wr(OFF_SAMPLE_CLOCK, 8'(sc));
         wr(OFF_PRESCALE_EXP, 8'(e)); wr(OFF_PRESCALE_OFF, 8'(o)); wr(OFF_MODE, 8'(i > 0));
         measure(rate_p(d, 16 - sc, e, o, i > 0), (i > 0) ? 16 - sc : 16);
         $display("rate test done");
      end
      wr(OFF_SAMPLE_CLOCK, 8'h0D); wr(OFF_PRESCALE_EXP, 8'h00);
      wr(OFF_PRESCALE_EXP, 8'h03); wr(OFF_PRESCALE_OFF, 8'h08);
      rd(OFF_SAMPLE_CLOCK, v);
      chk("sample clock", 16'(v), 16'(sc));
      rd(OFF_PRESCALE_EXP, v);
      chk("exponent", 16'(v), 16'(e));
      rd(OFF_PRESCALE_OFF, v);
      chk("offset", 16'(v), 16'(o));
      $display("refusal test done");
      wr(OFF_MODE, 8'h00); wr(OFF_DIV_LOW, 8'h01); wr(OFF_DIV_HIGH, 8'h00); wr(OFF_MODEM_CTRL, 8'h10);
      path_run(1'b1);
      rd(OFF_STATUS, v);
      chk("status", 16'(v), 16'h0005);
      wr(OFF_MODEM_CTRL, 8'h00);
      path_run(1'b0);
      report_and_stop();
   end
endmodule : testbench
bind uart_baud_gen_loopback uart_bg_checker uart_bg_checker_i (.mclk(mclk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in),
   .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .sample_tick(sample_tick),
   .bit_tick(bit_tick));
`default_nettype wire
